// *** hdl/cdfa_pkg.sv ***
// Constants, layouts and frame helpers shared by both ends of the data format accelerator.
// Assumes one clock (sys_clk) and a synchronous active-low reset on both ends.
package cdfa_pkg;
	// Register byte offsets on the peripheral bus
	localparam logic [15:0] CDFA_RA0_CTRL = 16'h0000;
	localparam logic [15:0] CDFA_RA0_STAT = 16'h0004;
	localparam logic [15:0] CDFA_RA0_IN = 16'h0008;
	localparam logic [15:0] CDFA_RA0_OUT = 16'h000c;
	localparam logic [15:0] CDFA_FUL_PAY_LO = 16'h0100;
	localparam logic [15:0] CDFA_FUL_PAY_HI = 16'h0104;
	localparam logic [15:0] CDFA_FUL_STAT = 16'h0108;
	localparam logic [15:0] CDFA_FUL_FRM_LO = 16'h010c;
	localparam logic [15:0] CDFA_FUL_FRM_HI = 16'h0110;
	localparam logic [15:0] CDFA_FDL_FRM_LO = 16'h0200;
	localparam logic [15:0] CDFA_FDL_FRM_HI = 16'h0204;
	localparam logic [15:0] CDFA_FDL_PAY_LO = 16'h0208;
	localparam logic [15:0] CDFA_FDL_PAY_HI = 16'h020c;
	localparam logic [15:0] CDFA_FDL_VOTE = 16'h0210;
	localparam logic [15:0] CDFA_SUL_PAY = 16'h0300;
	localparam logic [15:0] CDFA_SUL_STAT = 16'h0304;
	localparam logic [15:0] CDFA_SUL_FRM_LO = 16'h0308;
	localparam logic [15:0] CDFA_SUL_FRM_HI = 16'h030c;
	localparam logic [15:0] CDFA_SDL_FRM_LO = 16'h0400;
	localparam logic [15:0] CDFA_SDL_FRM_HI = 16'h0404;
	localparam logic [15:0] CDFA_SDL_PAY = 16'h0408;
	localparam logic [15:0] CDFA_SDL_VOTE = 16'h040c;
	localparam logic [15:0] CDFA_FAX_WORD_IN = 16'h0500;
	localparam logic [15:0] CDFA_FAX_WORD_OUT = 16'h0504;
	localparam logic [15:0] CDFA_FAX_BYTE_IN = 16'h0510;
	localparam logic [15:0] CDFA_FAX_BYTE_OUT = 16'h0514;

	// Control field positions and reset value
	localparam int CDFA_VLD_LSB = 0;
	localparam int CDFA_BTS_BIT = 4;
	localparam int CDFA_RST_BIT = 5;
	localparam logic [2:0] CDFA_VLD_RESET = 3'h4;
	localparam logic [2:0] CDFA_VLD_MAX = 3'h4;
	// Status field positions
	localparam int CDFA_RDY_LSB = 0;
	localparam int CDFA_STATE_LSB = 5;
	localparam int CDFA_TOTAL_LSB = 10;
	// Start/stop framing geometry
	localparam int CDFA_SEQ_BYTES = 16;
	localparam int CDFA_CHAR_BITS = 10;
	localparam int CDFA_WORDS = 5;
	localparam int CDFA_WORD_BITS = 32;

	typedef struct packed {
		logic [2:0] vld;
		logic [159:0] buf_bits;
		logic [3:0] pos;
		logic [4:0] rdy;
		logic bts_pend;
		logic [5:0] total;
		logic [47:0] ful_pay;
		logic [6:0] ful_st;
		logic [59:0] fdl_frm;
		logic [23:0] sul_pay;
		logic [6:0] sul_st;
		logic [35:0] sdl_frm;
		logic [31:0] fax_word;
		logic [31:0] fax_byte;
		logic [31:0] rdata;
	} cdfa_dev_state_t;

	typedef enum logic [1:0] {
		CDFA_IDLE = 2'h0,
		CDFA_SETUP = 2'h1,
		CDFA_ACCESS = 2'h3
	} cdfa_phase_t;

	typedef struct packed {
		cdfa_phase_t phase;
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
		logic rsp_valid;
		logic [31:0] rsp_rdata;
	} cdfa_host_state_t;

	// Status word 0..6: group a, group b, x, e4..e7
	function automatic logic [59:0] cdfa_fast_frame(input logic [47:0] d, input logic [6:0] s);
		return {s[1], d[47:42], s[0], d[41:36], s[2], d[35:30], s[0], d[29:24], s[6:3],
			s[1], d[23:18], s[0], d[17:12], s[2], d[11:6], s[0], d[5:0]};
	endfunction

	function automatic logic [35:0] cdfa_slow_frame(input logic [23:0] d, input logic [6:0] s);
		return {s[1], s[0], s[2], s[0], s[6:3], s[1], d[23:18], s[0], d[17:12], s[2],
			d[11:6], s[0], d[5:0]};
	endfunction

	// Majority of four, a two-two tie gives 0
	function automatic logic cdfa_maj4(input logic a, input logic b, input logic c, input logic d);
		return (a & b & c) | (a & b & d) | (a & c & d) | (b & c & d);
	endfunction
endpackage

// *** hdl/cdfa_apb_if.sv ***
// Peripheral bus between the accelerator and the processor side that drives it.
// Assumes both ends run on the same clock; no pready or error signal exists.
`timescale 1ns/1ps
interface cdfa_apb_if;
	logic psel;
	logic penable;
	logic pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;

	modport dev (input psel, input penable, input pwrite, input paddr, input pwdata,
		output prdata);
	modport host (output psel, output penable, output pwrite, output paddr, output pwdata,
		input prdata);
endinterface

// *** hdl/cdfa_dev.sv ***
// Data format accelerator: start/stop framing, fast and slow frame build/unpack, FAX reversal.
// Assumes a two-phase bus master on the same clock; reads and writes never overlap.
// Operation
// - Frame each byte with start and stop
// - Only valid byte count bytes are taken
// - Return command pads word, flags it ready
// - Pointer returns to zero after word read
// - Software waits for that word before writing
// - Converter reset clears pointer, counters, flags
// - Five ready flags, cleared when status read
// - Status shows state word being filled
// - Status shows running total of bytes
// - New input overwrites unread converted words
// - Output read returns lowest ready word
// - Fast uplink payload from two inputs
// - Uplink status bits fill frame status
// - Fast uplink frame across two outputs
// - Fast downlink frame unpacked to payload
// - Group a is majority of four
// - Group b and x voted, e copied
// - Slow uplink builds thirty-six bit frame
// - Slow downlink frame across two inputs
// - Word reverse of whole FAX word
// - Byte granular reverse of FAX word
// - Bus slave, 16-bit address, 32-bit data
`timescale 1ns/1ps
module cdfa_dev (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register bus
	cdfa_apb_if.dev bus
);
	import cdfa_pkg::*;

	localparam cdfa_dev_state_t RESET_STATE = '{vld: CDFA_VLD_RESET, buf_bits: '1,
		default: '0};

	cdfa_dev_state_t s_q;
	cdfa_dev_state_t s_d;

	// Bus phases: data is prepared in setup, side effects land in access
	logic setup_ph;
	logic write_acc;
	logic read_acc;
	assign setup_ph = bus.psel & ~bus.penable;
	assign write_acc = bus.psel & bus.penable & bus.pwrite;
	assign read_acc = bus.psel & bus.penable & ~bus.pwrite;
	assign bus.prdata = s_q.rdata;

	// Derived values from the stored frames
	logic [59:0] ful_frm;
	logic [35:0] sul_frm;
	logic [47:0] fdl_pay;
	logic [6:0] fdl_vote;
	logic [23:0] sdl_pay;
	logic [6:0] sdl_vote;
	logic [2:0] cur_state;
	assign ful_frm = cdfa_fast_frame(s_q.ful_pay, s_q.ful_st);
	assign sul_frm = cdfa_slow_frame(s_q.sul_pay, s_q.sul_st);
	assign fdl_pay = {s_q.fdl_frm[58:53], s_q.fdl_frm[51:46], s_q.fdl_frm[44:39],
		s_q.fdl_frm[37:32], s_q.fdl_frm[26:21], s_q.fdl_frm[19:14], s_q.fdl_frm[12:7],
		s_q.fdl_frm[5:0]};
	assign fdl_vote = {s_q.fdl_frm[31:28], s_q.fdl_frm[13] & s_q.fdl_frm[45],
		s_q.fdl_frm[27] & s_q.fdl_frm[59],
		cdfa_maj4(s_q.fdl_frm[6], s_q.fdl_frm[20], s_q.fdl_frm[38], s_q.fdl_frm[52])};
	assign sdl_pay = {s_q.sdl_frm[26:21], s_q.sdl_frm[19:14], s_q.sdl_frm[12:7],
		s_q.sdl_frm[5:0]};
	assign sdl_vote = {s_q.sdl_frm[31:28], s_q.sdl_frm[13] & s_q.sdl_frm[33],
		s_q.sdl_frm[27] & s_q.sdl_frm[35],
		cdfa_maj4(s_q.sdl_frm[6], s_q.sdl_frm[20], s_q.sdl_frm[32], s_q.sdl_frm[34])};
	// Word being filled is the fill bit position divided by the word width
	assign cur_state = 3'((32'(s_q.pos) * CDFA_CHAR_BITS) / CDFA_WORD_BITS);

	// Lowest ready word, used by both the read data and the withdrawal
	logic [2:0] out_idx;
	always_comb begin
		out_idx = 3'h0;
		for (int w = CDFA_WORDS - 1; w >= 0; w--) begin
			if (s_q.rdy[w]) begin
				out_idx = 3'(w);
			end
		end
	end

	// Next state of the whole block
	always_comb begin
		int bp;
		int nb;
		logic [4:0] q;
		bp = 0;
		nb = 0;
		q = 5'h0;
		s_d = s_q;
		if (setup_ph) begin
			// Read data is built one cycle ahead so it is a flop in the access phase
			s_d.rdata = 32'h0;
			if (!bus.pwrite) begin
				case (bus.paddr)
					CDFA_RA0_STAT: begin
						s_d.rdata[CDFA_RDY_LSB +: 5] = s_q.rdy;
						s_d.rdata[CDFA_STATE_LSB +: 5] = {2'h0, cur_state};
						s_d.rdata[CDFA_TOTAL_LSB +: 6] = s_q.total;
					end
					CDFA_RA0_OUT: begin
						if (|s_q.rdy) begin
							s_d.rdata = s_q.buf_bits[32'(out_idx) * CDFA_WORD_BITS +: 32];
						end
					end
					CDFA_FUL_FRM_LO: s_d.rdata = ful_frm[31:0];
					CDFA_FUL_FRM_HI: s_d.rdata = {4'h0, ful_frm[59:32]};
					CDFA_FDL_PAY_LO: s_d.rdata = fdl_pay[31:0];
					CDFA_FDL_PAY_HI: s_d.rdata = {16'h0, fdl_pay[47:32]};
					CDFA_FDL_VOTE: s_d.rdata = {25'h0, fdl_vote};
					CDFA_SUL_FRM_LO: s_d.rdata = sul_frm[31:0];
					CDFA_SUL_FRM_HI: s_d.rdata = {28'h0, sul_frm[35:32]};
					CDFA_SDL_PAY: s_d.rdata = {8'h0, sdl_pay};
					CDFA_SDL_VOTE: s_d.rdata = {25'h0, sdl_vote};
					CDFA_FAX_WORD_OUT: s_d.rdata = s_q.fax_word;
					CDFA_FAX_BYTE_OUT: s_d.rdata = s_q.fax_byte;
					default: s_d.rdata = 32'h0; // Unmapped and write-only read as zero
				endcase
			end
		end else if (!bus.psel) begin
			s_d.rdata = 32'h0;
		end

		if (read_acc) begin
			// Read side effects: withdrawal and flag clearing
			if (bus.paddr == CDFA_RA0_STAT) begin
				s_d.rdy = 5'h0;
			end else if (bus.paddr == CDFA_RA0_OUT && (|s_q.rdy)) begin
				s_d.rdy[out_idx] = 1'b0;
				if (s_q.bts_pend && out_idx == cur_state) begin
					s_d.pos = 4'h0;
					s_d.bts_pend = 1'b0;
				end
			end
		end

		if (write_acc) begin
			case (bus.paddr)
				CDFA_RA0_CTRL: begin
					s_d.vld = bus.pwdata[CDFA_VLD_LSB +: 3];
					if (bus.pwdata[CDFA_RST_BIT]) begin
						// Full converter restart, keeps the byte count just written
						s_d.buf_bits = '1;
						s_d.pos = 4'h0;
						s_d.rdy = 5'h0;
						s_d.total = 6'h0;
						s_d.bts_pend = 1'b0;
					end else if (bus.pwdata[CDFA_BTS_BIT] && s_q.pos != 4'h0) begin
						// Everything past the fill point becomes stop bits
						bp = 32'(s_q.pos) * CDFA_CHAR_BITS;
						s_d.buf_bits = s_q.buf_bits | ({160{1'b1}} << bp);
						s_d.rdy[cur_state] = 1'b1;
						s_d.bts_pend = 1'b1;
					end
				end
				CDFA_RA0_IN: begin
					// Values above four are taken as a full word
					nb = (s_q.vld > CDFA_VLD_MAX) ? 32'(CDFA_VLD_MAX) : 32'(s_q.vld);
					for (int k = 0; k < 4; k++) begin
						if (k < nb) begin
							q = 5'(s_q.pos) + 5'(k);
							bp = 32'(q[3:0]) * CDFA_CHAR_BITS;
							// Start bit low first, data LSB first, stop bit high last
							s_d.buf_bits[bp +: 10] = {1'b1, bus.pwdata[8 * k +: 8], 1'b0};
							for (int w = 0; w < CDFA_WORDS; w++) begin
								if (bp < CDFA_WORD_BITS * (w + 1) &&
									bp + CDFA_CHAR_BITS >= CDFA_WORD_BITS * (w + 1)) begin
									s_d.rdy[w] = 1'b1;
								end
							end
						end
					end
					s_d.pos = 4'(32'(s_q.pos) + nb);
					s_d.total = 6'(32'(s_q.total) + nb);
				end
				CDFA_FUL_PAY_LO: s_d.ful_pay[31:0] = bus.pwdata;
				CDFA_FUL_PAY_HI: s_d.ful_pay[47:32] = bus.pwdata[15:0];
				CDFA_FUL_STAT: s_d.ful_st = bus.pwdata[6:0];
				CDFA_FDL_FRM_LO: s_d.fdl_frm[31:0] = bus.pwdata;
				CDFA_FDL_FRM_HI: s_d.fdl_frm[59:32] = bus.pwdata[27:0];
				CDFA_SUL_PAY: s_d.sul_pay = bus.pwdata[23:0];
				CDFA_SUL_STAT: s_d.sul_st = bus.pwdata[6:0];
				CDFA_SDL_FRM_LO: s_d.sdl_frm[31:0] = bus.pwdata;
				CDFA_SDL_FRM_HI: s_d.sdl_frm[35:32] = bus.pwdata[3:0];
				CDFA_FAX_WORD_IN: begin
					for (int b = 0; b < 32; b++) begin
						s_d.fax_word[b] = bus.pwdata[31 - b];
					end
				end
				CDFA_FAX_BYTE_IN: begin
					for (int b = 0; b < 32; b++) begin
						s_d.fax_byte[b] = bus.pwdata[(b & 24) + 7 - (b & 7)];
					end
				end
				default: s_d.vld = s_q.vld; // Unmapped writes are dropped
			endcase
		end
	end

	// Single state register; enable low freezes everything
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q <= RESET_STATE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule // cdfa_dev

// *** hdl/cdfa_host.sv ***
// Processor-side end: turns one user command into a two-cycle bus transfer.
// Assumes the accelerator answers in the access phase with no wait states.
`timescale 1ns/1ps
module cdfa_host (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// User command
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [15:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	output logic cmd_ready,
	// User response
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	// Register bus
	cdfa_apb_if.host bus
);
	import cdfa_pkg::*;

	localparam cdfa_host_state_t RESET_STATE = '{phase: CDFA_IDLE, default: '0};

	cdfa_host_state_t h_q;
	cdfa_host_state_t h_d;

	// Bus pins straight from flops
	assign bus.psel = h_q.psel;
	assign bus.penable = h_q.penable;
	assign bus.pwrite = h_q.pwrite;
	assign bus.paddr = h_q.paddr;
	assign bus.pwdata = h_q.pwdata;
	assign cmd_ready = (h_q.phase == CDFA_IDLE) & clk_en;
	assign rsp_valid = h_q.rsp_valid;
	assign rsp_rdata = h_q.rsp_rdata;

	// Setup then access; back-to-back commands pass through idle once
	always_comb begin
		h_d = h_q;
		h_d.rsp_valid = 1'b0;
		case (h_q.phase)
			CDFA_IDLE: begin
				if (cmd_valid) begin
					h_d.phase = CDFA_SETUP;
					h_d.psel = 1'b1;
					h_d.pwrite = cmd_write;
					h_d.paddr = cmd_addr;
					h_d.pwdata = cmd_wdata;
				end
			end
			CDFA_SETUP: begin
				h_d.phase = CDFA_ACCESS;
				h_d.penable = 1'b1;
			end
			CDFA_ACCESS: begin
				h_d.phase = CDFA_IDLE;
				h_d.psel = 1'b0;
				h_d.penable = 1'b0;
				h_d.rsp_valid = 1'b1;
				h_d.rsp_rdata = h_q.pwrite ? 32'h0 : bus.prdata;
			end
			default: h_d = RESET_STATE;
		endcase
	end

	// Single state register; enable low freezes everything
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			h_q <= RESET_STATE;
		end else if (clk_en) begin
			h_q <= h_d;
		end
	end
endmodule // cdfa_host

// *** sim/cdfa_chk.sv ***
// Checker for the peripheral bus joining the host end to the accelerator.
// Assumes one clock and a synchronous active-low reset; clk_en drops only while idle.
`timescale 1ns/1ps
module cdfa_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Bus signals
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata
);
	import cdfa_pkg::*;
	logic [31:0] fw_q;
	logic [31:0] fb_q;
	logic [31:0] fw_rev;
	logic [31:0] fb_all;
	logic [31:0] fb_rev;
	wire acc = psel && penable;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Shadow the reversal inputs so results can be judged on their own
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fw_q <= 32'h0;
			fb_q <= 32'h0;
		end else if (acc && pwrite) begin
			if (paddr == CDFA_FAX_WORD_IN)
				fw_q <= pwdata;
			if (paddr == CDFA_FAX_BYTE_IN)
				fb_q <= pwdata;
		end
	end
	// Word reversal flips all 32 bits; byte reversal flips bit order inside a byte, byte positions stay
	always_comb begin
		fw_rev = {<<{fw_q}};
		fb_all = {<<{fb_q}};
		fb_rev = {<<8{fb_all}};
	end
	a_setup_then_access: assert property (psel && !penable |=> psel && penable)
		else $error("setup not followed by access");
	a_access_ends: assert property (acc |=> !psel && !penable)
		else $error("access phase did not end");
	a_enable_needs_sel: assert property (penable |-> psel)
		else $error("enable without select");
	a_request_steady: assert property (psel && !penable |=> $stable(paddr) && $stable(pwrite)
		&& $stable(pwdata))
		else $error("request changed before access");
	a_idle_rdata_zero: assert property (!psel ##1 !psel |-> prdata == 32'h0)
		else $error("read data not zero while idle");
	a_wo_read_zero: assert property (acc && !pwrite && (paddr == CDFA_RA0_CTRL
		|| paddr == CDFA_RA0_IN || paddr == CDFA_FAX_WORD_IN) |-> prdata == 32'h0)
		else $error("write-only place read nonzero");
	a_word_reverse: assert property (acc && !pwrite && paddr == CDFA_FAX_WORD_OUT
		|-> prdata == fw_rev)
		else $error("word reversal wrong");
	a_byte_reverse: assert property (acc && !pwrite && paddr == CDFA_FAX_BYTE_OUT
		|-> prdata == fb_rev)
		else $error("byte reversal wrong");
endmodule // cdfa_chk

// *** sim/testbench.sv ***
// Self-checking bench: drives the host command port, checks results read back.
// Assumes a 250 MHz clock; clk_en is dropped only while the bus is idle.
`timescale 1ns/1ps
module testbench;
	import cdfa_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [15:0] cmd_addr = 16'h0;
	logic [31:0] cmd_wdata = 32'h0;
	logic cmd_ready;
	logic rsp_valid;
	logic [31:0] rsp_rdata;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] c;
	logic [31:0] r;
	logic [59:0] f;
	logic [47:0] g;
	logic [159:0] mb;
	logic [4:0] mr;
	int seed = 32'hd69b;
	int failures = 0;
	int n_checks = 0;
	int mp;
	int mt;
	int cyc = 0;
	cdfa_apb_if bus ();
	cdfa_dev u_cdfa_dev (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus));
	cdfa_host u_cdfa_host (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .bus(bus));
	cdfa_chk u_cdfa_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(bus.psel),
		.penable(bus.penable), .pwrite(bus.pwrite), .paddr(bus.paddr),
		.pwdata(bus.pwdata), .prdata(bus.prdata));
	// Half period of 2 ns
	always #2 sys_clk = ~sys_clk;
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard: the whole run needs far fewer cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end
	// One command, held until taken, then wait for its response pulse
	task automatic xfer(input logic w, input logic [15:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= ad;
		cmd_wdata <= d;
		@(negedge sys_clk);
		while (cmd_ready !== 1'b1)
			@(negedge sys_clk);
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 9);
		if (n == 9) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
		r = rsp_rdata;
	endtask
	task automatic wr(input logic [15:0] ad, input logic [31:0] d);
		xfer(1'b1, ad, d);
	endtask
	task automatic rd(input logic [15:0] ad, input logic [31:0] e);
		xfer(1'b0, ad, 32'h0);
		n_checks++;
		if (r !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, r, e);
		end
	endtask
	// Start/stop framing model: ten bits a byte, word ready when its top bit lands
	task automatic mput(input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			mb[10*mp+:10] = {1'b1, w[8*i+:8], 1'b0};
			for (int j = 0; j < 5; j++)
				if (32*j+31 >= 10*mp && 32*j+31 < 10*mp+10)
					mr[j] = 1'b1;
			mp = (mp + 1) % 16;
			mt++;
		end
	endtask
	task automatic rout();
		int k;
		k = 5;
		for (int j = 4; j >= 0; j--)
			if (mr[j])
				k = j;
		rd(CDFA_RA0_OUT, (k < 5) ? mb[32*k+:32] : 32'h0);
		if (k < 5)
			mr[k] = 1'b0;
	endtask
	task automatic rst_st();
		rd(CDFA_RA0_STAT, {16'h0, 6'(mt), 5'(10*mp/32), mr});
		mr = 5'h0;
	endtask
	// Frame built from the status positions; every other bit takes the next payload bit
	function automatic logic [59:0] ff(input logic [47:0] d, input logic [6:0] s);
		logic [59:0] q;
		int n;
		q = '0;
		n = 0;
		for (int i = 0; i < 60; i++) begin
			case (i)
				6, 20, 38, 52: q[i] = s[0];
				27, 59: q[i] = s[1];
				13, 45: q[i] = s[2];
				28, 29, 30, 31: q[i] = s[i - 25];
				default: begin
					q[i] = d[n];
					n++;
				end
			endcase
		end
		return q;
	endfunction
	function automatic logic [47:0] fd(input logic [59:0] q);
		logic [47:0] d;
		int n;
		d = '0;
		n = 0;
		for (int i = 0; i < 60; i++) begin
			if (!(i inside {6, 13, 20, 27, 28, 29, 30, 31, 38, 45, 52, 59})) begin
				d[n] = q[i];
				n++;
			end
		end
		return d;
	endfunction
	// Two-two ties vote 0
	function automatic logic [31:0] vt(input logic [59:0] q);
		logic [2:0] k;
		k = 3'(q[6]) + 3'(q[20]) + 3'(q[38]) + 3'(q[52]);
		return {25'h0, q[31:28], q[13] & q[45], q[27] & q[59], k >= 3'h3};
	endfunction
	initial begin
		mb = '1;
		mp = 0;
		mt = 0;
		mr = 5'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rst_st();
		rd(CDFA_RA0_CTRL, 32'h0);
		rd(16'h0ff0, 32'h0);
		rd(CDFA_FDL_VOTE, 32'h0);
		$display("test reset done");
		// Sixteen bytes at the reset count, then two words ready together
		for (int i = 0; i < 4; i++) begin
			a = $random(seed);
			wr(CDFA_RA0_IN, a);
			mput(a, 4);
			rout();
		end
		rst_st();
		rout();
		$display("test framing done");
		// Mid-run converter reset, short count, then return to the first state
		wr(CDFA_RA0_IN, a);
		wr(CDFA_RA0_CTRL, 32'h23);
		mb = '1;
		mp = 0;
		mt = 0;
		mr = 5'h0;
		rst_st();
		a = $random(seed);
		wr(CDFA_RA0_IN, a);
		mput(a, 3);
		wr(CDFA_RA0_CTRL, 32'h4);
		wr(CDFA_RA0_IN, ~a);
		mput(~a, 4);
		rout();
		rout();
		wr(CDFA_RA0_CTRL, 32'h14);
		for (int i = 10 * mp; i < 160; i++)
			mb[i] = 1'b1;
		mr[10*mp/32] = 1'b1;
		rout();
		mp = 0;
		rst_st();
		$display("test return done");
		// Frames and reversals on random words, first pass a vote-tie corner
		for (int i = 0; i < 8; i++) begin
			a = $random(seed);
			b = (i == 0) ? 32'hffffffff : $random(seed);
			c = (i == 0) ? 32'h0 : $random(seed);
			wr(CDFA_FUL_PAY_LO, a);
			wr(CDFA_FUL_PAY_HI, b);
			wr(CDFA_FUL_STAT, c);
			f = ff({b[15:0], a}, c[6:0]);
			rd(CDFA_FUL_FRM_LO, f[31:0]);
			rd(CDFA_FUL_FRM_HI, {4'h0, f[59:32]});
			wr(CDFA_SUL_PAY, a);
			wr(CDFA_SUL_STAT, c);
			f = ff({24'h0, a[23:0]}, c[6:0]);
			rd(CDFA_SUL_FRM_LO, f[31:0]);
			rd(CDFA_SUL_FRM_HI, {28'h0, c[1], c[0], c[2], c[0]});
			wr(CDFA_FDL_FRM_LO, b);
			wr(CDFA_FDL_FRM_HI, c);
			f = {c[27:0], b};
			g = fd(f);
			rd(CDFA_FDL_PAY_LO, g[31:0]);
			rd(CDFA_FDL_PAY_HI, {16'h0, g[47:32]});
			rd(CDFA_FDL_VOTE, vt(f));
			wr(CDFA_SDL_FRM_LO, b);
			wr(CDFA_SDL_FRM_HI, c);
			rd(CDFA_SDL_PAY, {8'h0, g[23:0]});
			rd(CDFA_SDL_VOTE, vt({c[3], 6'h0, c[2], 6'h0, c[1], 6'h0, c[0], 6'h0, b}));
			wr(CDFA_FAX_WORD_IN, a);
			r = {<<{a}};
			rd(CDFA_FAX_WORD_OUT, r);
			wr(CDFA_FAX_BYTE_IN, a);
			r = {<<{a}};
			r = {<<8{r}};
			rd(CDFA_FAX_BYTE_OUT, r);
		end
		$display("test frames done");
		// Enable low: the command waits with the bus idle, then goes through
		b = ~a;
		@(posedge sys_clk);
		clk_en <= 1'b0;
		fork
			wr(CDFA_FAX_WORD_IN, b);
			begin
				repeat (3) begin
					@(negedge sys_clk);
					n_checks++;
					if ({cmd_ready, bus.psel} !== 2'h0) begin
						failures++;
						$display("[FAIL] t=%0t got=%h exp=%h", $time, {cmd_ready, bus.psel}, 2'h0);
					end
				end
				@(posedge sys_clk);
				clk_en <= 1'b1;
			end
		join
		r = {<<{b}};
		rd(CDFA_FAX_WORD_OUT, r);
		$display("test enable done");
		summarize();
	end
endmodule // testbench
